/* core/dsb_ctrl.sv */
`timescale 1ns/1ps
module dsb_ctrl import dsb_pkg::*; #(
  parameter int STUCK_RUN = STUCK_RUN_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic frame_clk_i,
  input wire logic [5:0] stream_i,
  input wire logic speed_pin_high,
  input wire logic speed_pin_mid,
  input wire logic deemph_speed_pin,
  input wire logic [1:0] ratio_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  output logic [7:0] reg_rdata,
  input wire logic [5:0] mute_drive_pins_i,
  output logic [5:0] mute_drive_pins_o,
  output logic [5:0] mute_drive_pins_oe,
  output dsb_pcm_cfg_t pcm_cfg,
  output logic [7:0] osr_out,
  output logic [10:0] fs_period,
  output logic [11:0] mix_code,
  output dsb_bs_cfg_t bs_cfg,
  output logic [3:0] bs_mclk_ratio,
  output logic [7:0] bs_osr,
  output logic [5:0] stream_attn,
  output logic [5:0] stream_fill
);

  if (STUCK_RUN < 2 || STUCK_RUN > 255) begin : g_bad_param
    $error("STUCK_RUN out of range");
  end

  localparam logic [7:0] STUCK_LIM = 8'(STUCK_RUN);

  function automatic logic [3:0] ratio_decode(input logic [2:0] r);
    logic [3:0] v;
    v = 4'h4;
    unique case (r)
      3'h0: v = 4'h4;
      3'h1: v = 4'h6;
      3'h2: v = 4'h8;
      3'h3: v = 4'hc;
      3'h4: v = 4'h2;
      3'h5: v = 4'h3;
      3'h6: v = 4'h4;
      3'h7: v = 4'h6;
    endcase
    return v;
  endfunction : ratio_decode

  function automatic logic [7:0] osr_decode(input dsb_speed_t s);
    logic [7:0] v;
    v = OSR_SSM;
    unique case (s)
      SPD_SINGLE: v = OSR_SSM;
      SPD_DOUBLE: v = OSR_DSM;
      SPD_QUAD: v = OSR_QSM;
      SPD_AUTO: v = OSR_SSM;
    endcase
    return v;
  endfunction : osr_decode

  // link domain: reset and config arrive through two flops
  logic lrst_s1, lrst;
  logic pm_l1, pm_l2;
  always_ff @(posedge link_clk) begin
    lrst_s1 <= sys_rst;
    lrst <= lrst_s1;
    pm_l1 <= bs_cfg.pm_en;
    pm_l2 <= pm_l1;
  end

  logic lrck_q, frame_tgl_l;
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      lrck_q <= 1'b0;
      frame_tgl_l <= 1'b0;
    end else begin
      lrck_q <= frame_clk_i;
      if (frame_clk_i && !lrck_q) begin
        frame_tgl_l <= ~frame_tgl_l;
      end
    end
  end

  logic [5:0] stuck_l, bad_l;
  for (genvar i = 0; i < 6; i++) begin : g_chk
    logic prev;
    logic phase;
    logic [7:0] run, clean;
    always_ff @(posedge link_clk) begin
      if (lrst) begin
        prev <= 1'b0;
        phase <= 1'b0;
        run <= 8'h00;
        clean <= 8'h00;
        stuck_l[i] <= 1'b0;
        bad_l[i] <= 1'b0;
      end else begin
        prev <= stream_i[i];
        if (stream_i[i] == prev) begin
          if (run != STUCK_LIM) begin
            run <= run + 8'h01;
          end
        end else begin
          run <= 8'h00;
        end
        stuck_l[i] <= (run == STUCK_LIM);
        phase <= pm_l2 ? ~phase : 1'b0;
        // held over a clean run of pairs so the crossing sees a level
        if (!pm_l2) begin
          bad_l[i] <= 1'b0;
          clean <= 8'h00;
        end else if (phase) begin
          clean <= (stream_i[i] == prev) ? 8'h00 : clean + {7'h00, clean != STUCK_LIM};
          bad_l[i] <= (stream_i[i] == prev) || (bad_l[i] && clean != STUCK_LIM);
        end
      end
    end
  end

  // sys domain crossings
  logic ftg_s1, ftg_s2, ftg_s3;
  logic [5:0] stuck_s1, stuck_s, bad_s1, bad_s;
  logic [4:0] pins_s1, pins_s;
  logic [5:0] mpin_s1, mpin_s;
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      ftg_s1 <= frame_tgl_l;
      ftg_s2 <= ftg_s1;
      ftg_s3 <= ftg_s2;
      stuck_s1 <= stuck_l;
      stuck_s <= stuck_s1;
      bad_s1 <= bad_l;
      bad_s <= bad_s1;
      pins_s1 <= {speed_pin_high, speed_pin_mid, deemph_speed_pin, ratio_pin};
      pins_s <= pins_s1;
      mpin_s1 <= mute_drive_pins_i;
      mpin_s <= mpin_s1;
    end
  end
  logic frame_evt;
  assign frame_evt = ftg_s2 ^ ftg_s3;

  logic [10:0] frame_cnt;
  dsb_speed_t det_speed;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frame_cnt <= 11'h000;
      fs_period <= 11'h000;
      det_speed <= SPD_SINGLE;
    end else if (ce) begin
      if (frame_evt) begin
        frame_cnt <= 11'h001;
        // measured period, filters track the true rate
        fs_period <= frame_cnt;
        if (frame_cnt >= SSM_MIN_CYC) begin
          det_speed <= SPD_SINGLE;
        end else if (frame_cnt >= DSM_MIN_CYC) begin
          det_speed <= SPD_DOUBLE;
        end else begin
          det_speed <= SPD_QUAD;
        end
      end else if (frame_cnt != FRAME_CNT_MAX) begin
        frame_cnt <= frame_cnt + 11'h001;
      end
    end
  end

  logic [7:0] fmt_reg, mode_reg, bs_reg, mix_a_reg, mix_b_reg, mute_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fmt_reg <= RST_STREAM_FMT;
      mode_reg <= RST_MODE;
      bs_reg <= RST_BITSTREAM;
      mix_a_reg <= RST_MIX;
      mix_b_reg <= RST_MIX;
      mute_reg <= RST_MUTE;
    end else if (ce && reg_we) begin
      unique case (reg_addr)
        ADDR_STREAM_FMT: fmt_reg <= reg_wdata;
        ADDR_MODE: mode_reg <= reg_wdata;
        ADDR_BITSTREAM: bs_reg <= reg_wdata;
        ADDR_MIX_A: mix_a_reg <= reg_wdata;
        ADDR_MIX_B: mix_b_reg <= reg_wdata;
        ADDR_MUTE: mute_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  logic pol_ready;
  logic [5:0] mute_pol;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      unique case (reg_addr)
        ADDR_STREAM_FMT: reg_rdata <= fmt_reg;
        ADDR_MODE: reg_rdata <= mode_reg;
        ADDR_BITSTREAM: reg_rdata <= bs_reg;
        ADDR_MIX_A: reg_rdata <= mix_a_reg;
        ADDR_MIX_B: reg_rdata <= mix_b_reg;
        ADDR_MUTE: reg_rdata <= mute_reg;
        ADDR_STATUS: reg_rdata <= {3'h0, pol_ready, |bad_s, |stuck_s, det_speed};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // pending settings from pins or registers
  dsb_pcm_cfg_t next_pcm;
  dsb_bs_cfg_t next_bs;
  logic hw_stream;
  always_comb begin
    hw_stream = pins_s[4] && pins_s[3];
    next_pcm.sw = mode_reg[MODE_SW_BIT];
    if (mode_reg[MODE_SW_BIT]) begin
      next_pcm.speed = dsb_speed_t'(mode_reg[MODE_SPEED_LSB +: 2]);
      next_pcm.slow = mode_reg[MODE_SLOW_BIT];
      next_pcm.deemph = dsb_deemph_t'(mode_reg[MODE_DEEMPH_LSB +: 2]);
      next_bs.on = fmt_reg[FMT_STREAM_BIT];
      next_bs.ratio = bs_reg[BS_RATIO_LSB +: 3];
      next_bs.bypass = bs_reg[BS_BYPASS_BIT];
      next_bs.pm_en = bs_reg[BS_PM_EN_BIT];
      next_bs.pm_clk = bs_reg[BS_PM_CLK_BIT];
      next_bs.stuck_h = bs_reg[BS_STUCK_BIT];
      next_bs.bad_h = bs_reg[BS_BAD_BIT];
    end else begin
      unique case (pins_s[4:3])
        2'b00: next_pcm.speed = SPD_SINGLE;
        2'b01: next_pcm.speed = pins_s[2] ? SPD_QUAD : SPD_DOUBLE;
        2'b10: next_pcm.speed = SPD_AUTO;
        2'b11: next_pcm.speed = SPD_SINGLE;
      endcase
      next_pcm.slow = 1'b0;
      next_pcm.deemph = (pins_s[2] && !pins_s[3]) ? DE_441 : DE_OFF;
      next_bs.on = hw_stream;
      next_bs.ratio = pins_s[2:0];
      next_bs.bypass = 1'b0;
      next_bs.pm_en = 1'b0;
      next_bs.pm_clk = 1'b0;
      next_bs.stuck_h = 1'b1;
      next_bs.bad_h = 1'b1;
    end
    // auto resolves to the measured speed
    if (next_pcm.speed == SPD_AUTO) begin
      next_pcm.speed = det_speed;
    end
  end

  // applied only at a frame boundary
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pcm_cfg <= '{sw: 1'b0, speed: SPD_SINGLE, slow: 1'b0, deemph: DE_OFF};
      osr_out <= OSR_SSM;
      bs_cfg <= '0;
      bs_mclk_ratio <= 4'h4;
      bs_osr <= BS_OSR_64;
    end else if (ce && frame_evt) begin
      pcm_cfg <= next_pcm;
      osr_out <= osr_decode(next_pcm.speed);
      bs_cfg <= next_bs;
      bs_mclk_ratio <= ratio_decode(next_bs.ratio);
      bs_osr <= next_bs.ratio[2] ? BS_OSR_128 : BS_OSR_64;
    end
  end

  logic [11:0] mix_src;
  assign mix_src = {mix_b_reg[3:0], mix_a_reg};
  for (genvar p = 0; p < 3; p++) begin : g_mix
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        mix_code[4*p +: 4] <= RST_MIX[3:0];
      end else if (ce && frame_evt) begin
        mix_code[4*p +: 4] <= mix_src[4*p +: 4];
      end
    end
  end

  // stuck is mute-filled, invalid is attenuated
  logic [5:0] mute_act;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stream_fill <= 6'h00;
      stream_attn <= 6'h00;
    end else if (ce) begin
      stream_fill <= (bs_cfg.on && bs_cfg.stuck_h) ? stuck_s : 6'h00;
      stream_attn <= (bs_cfg.on && bs_cfg.bad_h) ? (bad_s & ~stuck_s) : 6'h00;
    end
  end
  assign mute_act = mute_reg[MUTE_REQ_LSB +: 6] | (mute_reg[MUTE_AUTO_BIT] ? stream_fill : 6'h00);

  // polarity taken once the pin sync has settled
  logic [1:0] pol_cnt;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pol_cnt <= 2'h0;
      pol_ready <= 1'b0;
      mute_pol <= 6'h00;
    end else if (ce && !pol_ready) begin
      pol_cnt <= pol_cnt + 2'h1;
      if (pol_cnt == POL_CAPTURE_CYC - 2'h1) begin
        pol_ready <= 1'b1;
        mute_pol <= mpin_s;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mute_drive_pins_oe <= 6'h00;
      mute_drive_pins_o <= 6'h00;
    end else if (ce) begin
      mute_drive_pins_oe <= {6{pol_ready}};
      mute_drive_pins_o <= (mute_act & mute_pol) | (~mute_act & ~mute_pol);
    end
  end

  // shared volume lies outside; no per-format gain kept here

  a_osr_single: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pcm_cfg.speed == SPD_SINGLE |-> osr_out == 8'h80) else $error("single speed osr wrong");
  a_osr_double: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pcm_cfg.speed == SPD_DOUBLE |-> osr_out == 8'h40) else $error("double speed osr wrong");
  a_osr_quad: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pcm_cfg.speed == SPD_QUAD |-> osr_out == 8'h20) else $error("quad speed osr wrong");
  a_hw_fast_filter: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pcm_cfg.sw |-> !pcm_cfg.slow) else $error("slow filter in hardware mode");
  a_hw_deemph_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pcm_cfg.sw |-> pcm_cfg.deemph inside {DE_OFF, DE_441}) else $error("hw deemph rate wrong");
  a_fmt_reg_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && reg_we && reg_addr == ADDR_STREAM_FMT |=> fmt_reg == $past(reg_wdata))
    else $error("format register not written");
  a_frame_apply: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $changed(pcm_cfg) |-> $past(frame_evt) && $past(ce)) else $error("mode changed mid frame");
  a_mute_undriven: assert property (@(posedge sys_clk)
    sys_rst |=> mute_drive_pins_oe == 6'h00) else $error("mute pins driven in reset");
  a_mute_polarity: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && pol_ready && mute_act[0] |=> mute_drive_pins_o[0] == mute_pol[0] && mute_drive_pins_oe[0])
    else $error("mute drive polarity wrong");
  a_pol_capture: assert property (@(posedge sys_clk)
    ($fell(sys_rst) && ce) ##1 ce [*2] |-> !pol_ready ##1 pol_ready) else $error("polarity not captured");
  a_fill_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    stream_fill != 6'h00 |-> $past(bs_cfg.on && bs_cfg.stuck_h)) else $error("fill without enable");

endmodule : dsb_ctrl

/* pkg/dsb_pkg.sv */
package dsb_pkg;

  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned SSM_MAX_HZ = 50_000;
  localparam int unsigned DSM_MAX_HZ = 100_000;
  localparam int unsigned QSM_MAX_HZ = 200_000;
  // frame periods in sys_clk cycles at the upper rate of single and double speed
  localparam logic [10:0] SSM_MIN_CYC = 11'(SYS_CLK_HZ / SSM_MAX_HZ);
  localparam logic [10:0] DSM_MIN_CYC = 11'(SYS_CLK_HZ / DSM_MAX_HZ);
  localparam logic [10:0] FRAME_CNT_MAX = 11'h7ff;

  localparam logic [7:0] OSR_SSM = 8'h80;
  localparam logic [7:0] OSR_DSM = 8'h40;
  localparam logic [7:0] OSR_QSM = 8'h20;
  localparam logic [7:0] BS_OSR_64 = 8'h40;
  localparam logic [7:0] BS_OSR_128 = 8'h80;

  localparam logic [7:0] ADDR_STREAM_FMT = 8'h02;
  localparam logic [7:0] ADDR_MODE = 8'h03;
  localparam logic [7:0] ADDR_BITSTREAM = 8'h04;
  localparam logic [7:0] ADDR_MIX_A = 8'h05;
  localparam logic [7:0] ADDR_MIX_B = 8'h06;
  localparam logic [7:0] ADDR_MUTE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0a;

  localparam logic [7:0] RST_STREAM_FMT = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h03;
  localparam logic [7:0] RST_BITSTREAM = 8'h00;
  localparam logic [7:0] RST_MIX = 8'h99;
  localparam logic [7:0] RST_MUTE = 8'h01;

  localparam int FMT_STREAM_BIT = 0;
  localparam int MODE_SPEED_LSB = 0;
  localparam int MODE_SLOW_BIT = 2;
  localparam int MODE_DEEMPH_LSB = 3;
  localparam int MODE_SW_BIT = 7;
  localparam int BS_RATIO_LSB = 0;
  localparam int BS_BYPASS_BIT = 3;
  localparam int BS_PM_EN_BIT = 4;
  localparam int BS_PM_CLK_BIT = 5;
  localparam int BS_STUCK_BIT = 6;
  localparam int BS_BAD_BIT = 7;
  localparam int MUTE_AUTO_BIT = 0;
  localparam int MUTE_REQ_LSB = 1;

  localparam logic [1:0] POL_CAPTURE_CYC = 2'h3;
  localparam int STUCK_RUN_DEFAULT = 28;

  typedef enum logic [1:0] {
    SPD_SINGLE = 2'b00,
    SPD_DOUBLE = 2'b01,
    SPD_QUAD = 2'b10,
    SPD_AUTO = 2'b11
  } dsb_speed_t;

  typedef enum logic [1:0] {
    DE_OFF = 2'b00,
    DE_441 = 2'b01,
    DE_48 = 2'b10,
    DE_32 = 2'b11
  } dsb_deemph_t;

  typedef struct packed {
    logic sw;
    dsb_speed_t speed;
    logic slow;
    dsb_deemph_t deemph;
  } dsb_pcm_cfg_t;

  typedef struct packed {
    logic on;
    logic [2:0] ratio;
    logic bypass;
    logic pm_en;
    logic pm_clk;
    logic stuck_h;
    logic bad_h;
  } dsb_bs_cfg_t;

endpackage : dsb_pkg

/* verification/dac_speed_filter_bitstream_ctrl_test.sv */
`timescale 1ns/1ps
module dac_speed_filter_bitstream_ctrl_test import dsb_pkg::*;;
  typedef struct packed {
    logic [7:0] mreg;
    logic [2:0] pins;
    logic [11:0] per;
    logic [5:0] cfg;
    logic [7:0] osr;
  } dsb_row_t;
  logic sys_clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, link_clk = 1'b0, link_run = 1'b1;
  logic spd_h = 1'b0, spd_m = 1'b0, spd_d = 1'b0, reg_we = 1'b0, pm_bad = 1'b0, src_run = 1'b1;
  logic [1:0] ratio_pin = 2'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, osr, bs_osr, rv;
  logic [5:0] bias = 6'h2a, stuck_mask = 6'h00, pin_lvl, mute_o, mute_oe, attn, fill, stream;
  logic frame_clk;
  logic [11:0] period = 12'd200;
  logic [11:0] mix;
  logic [10:0] fs_period;
  logic [3:0] mclk;
  dsb_pcm_cfg_t pcm_cfg;
  dsb_bs_cfg_t bs_cfg;
  int miscompares = 0, num_checks = 0, cyc = 0;
  logic [7:0] ra [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h07};
  logic [7:0] rx [7] = '{8'h00, 8'h03, 8'h00, 8'h99, 8'h99, 8'h01, 8'h00};
  logic [3:0] mx [8] = '{4'h4, 4'h6, 4'h8, 4'hc, 4'h2, 4'h3, 4'h4, 4'h6};
  dsb_row_t rows [18] = '{
    '{8'h04, 3'b000, 12'd200, 6'h00, 8'h80}, '{8'h00, 3'b001, 12'd200, 6'h01, 8'h80},
    '{8'h00, 3'b010, 12'd200, 6'h08, 8'h40}, '{8'h00, 3'b011, 12'd200, 6'h10, 8'h20},
    '{8'h00, 3'b100, 12'd1400, 6'h00, 8'h80}, '{8'h00, 3'b101, 12'd200, 6'h11, 8'h20},
    '{8'h00, 3'b100, 12'd700, 6'h08, 8'h40}, '{8'h80, 3'b011, 12'd200, 6'h20, 8'h80},
    '{8'h81, 3'b011, 12'd200, 6'h28, 8'h40}, '{8'h82, 3'b011, 12'd200, 6'h30, 8'h20},
    '{8'h83, 3'b011, 12'd1400, 6'h20, 8'h80}, '{8'h83, 3'b011, 12'd700, 6'h28, 8'h40},
    '{8'h83, 3'b011, 12'd200, 6'h30, 8'h20}, '{8'h84, 3'b011, 12'd200, 6'h24, 8'h80},
    '{8'h86, 3'b011, 12'd200, 6'h34, 8'h20}, '{8'h88, 3'b011, 12'd200, 6'h21, 8'h80},
    '{8'h90, 3'b011, 12'd200, 6'h22, 8'h80}, '{8'h98, 3'b011, 12'd200, 6'h23, 8'h80}};

  always #10 sys_clk = ~sys_clk;
  // link clock stands still while link_run is low
  always #7.5 link_clk = link_run ? ~link_clk : 1'b0;
  // undriven mute pins fall back to their external bias
  assign pin_lvl = (mute_oe & mute_o) | (~mute_oe & bias);

  dsb_src_model src (.link_clk(link_clk), .run(src_run), .pm_bad(pm_bad), .period(period),
    .stuck_mask(stuck_mask), .frame_clk_o(frame_clk), .stream_o(stream));

  dsb_ctrl #(.STUCK_RUN(4)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .link_clk(link_clk),
    .frame_clk_i(frame_clk), .stream_i(stream), .speed_pin_high(spd_h), .speed_pin_mid(spd_m),
    .deemph_speed_pin(spd_d), .ratio_pin(ratio_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_rdata(rdata), .mute_drive_pins_i(pin_lvl), .mute_drive_pins_o(mute_o),
    .mute_drive_pins_oe(mute_oe), .pcm_cfg(pcm_cfg), .osr_out(osr), .fs_period(fs_period),
    .mix_code(mix), .bs_cfg(bs_cfg), .bs_mclk_ratio(mclk), .bs_osr(bs_osr), .stream_attn(attn),
    .stream_fill(fill));

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic frames(input int n);
    repeat (n) @(posedge frame_clk);
    tick(10);
  endtask : frames

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge sys_clk);
    reg_we <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    tick(2);
    d = rdata;
  endtask : rd

  function automatic logic [5:0] mute_exp(input logic [5:0] p, input logic [5:0] m);
    return (p & m) | (~p & ~m & 6'h3f);
  endfunction : mute_exp

  task automatic do_reset(input logic [5:0] b);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    bias <= b;
    tick(3);
    chk(16'(mute_oe), 16'h0000);
    chk({osr, bs_osr}, 16'h8040);
    chk({mclk, mix}, 16'h4999);
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(8);
    chk(16'(mute_oe), 16'h003f);
    wr(8'h08, 8'h7f);
    frames(2);
    chk(16'(mute_o), 16'(b));
    wr(8'h08, 8'h01);
    frames(2);
    chk(16'(mute_o), 16'(mute_exp(b, 6'h00)));
  endtask : do_reset

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    do_reset(6'h2a);
    // frozen write and unmapped write must both be dropped
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(8'h05, 8'hff);
    @(posedge sys_clk);
    ce <= 1'b1;
    wr(8'h07, 8'hff);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], rv);
      chk(16'(rv), 16'(rx[i]));
    end
    foreach (rows[i]) begin
      @(posedge sys_clk);
      {spd_h, spd_m, spd_d} <= rows[i].pins;
      period <= rows[i].per;
      wr(8'h03, rows[i].mreg);
      frames(3);
      chk(16'(pcm_cfg), 16'(rows[i].cfg));
      chk(16'(osr), 16'(rows[i].osr));
    end
    wr(8'h05, 8'h5a);
    wr(8'h06, 8'h03);
    frames(2);
    chk(16'(mix), 16'h035a);
    wr(8'h02, 8'h01);
    for (int c = 0; c < 8; c++) begin
      rv = {c[2:0], c[1:0], c[2:0]};
      wr(8'h04, rv);
      frames(2);
      chk(16'(bs_cfg), {7'h00, 1'b1, rv[2:0], rv[3], rv[4], rv[5], rv[6], rv[7]});
      chk({4'h0, mclk, bs_osr}, {4'h0, mx[c], c[2] ? 8'h80 : 8'h40});
    end
    // one channel held constant
    wr(8'h04, 8'h40);
    @(posedge sys_clk);
    stuck_mask <= 6'h04;
    frames(2);
    chk(16'(fill), 16'h0004);
    chk(16'(mute_o), 16'(mute_exp(6'h2a, 6'h04)));
    wr(8'h04, 8'h00);
    frames(2);
    chk(16'(fill), 16'h0000);
    @(posedge sys_clk);
    stuck_mask <= 6'h00;
    wr(8'h04, 8'h90);
    @(posedge sys_clk);
    pm_bad <= 1'b1;
    frames(2);
    chk(16'(attn), 16'h0001);
    @(posedge sys_clk);
    pm_bad <= 1'b0;
    frames(2);
    chk(16'(attn), 16'h0000);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    @(posedge sys_clk);
    {spd_h, spd_m, spd_d} <= 3'b111;
    ratio_pin <= 2'b10;
    frames(2);
    chk(16'(bs_cfg), {7'h00, 1'b1, 3'b110, 5'b00011});
    chk({4'h0, mclk, bs_osr}, 16'h0480);
    @(posedge sys_clk);
    {spd_h, spd_m, spd_d} <= 3'b000;
    wr(8'h03, 8'h80);
    frames(2);
    // no frames: new mode must wait
    @(posedge sys_clk);
    src_run <= 1'b0;
    repeat (20) @(posedge sys_clk);
    link_run <= 1'b0;
    wr(8'h03, 8'h82);
    tick(10);
    chk(16'(pcm_cfg), 16'h0020);
    rd(8'h03, rv);
    chk(16'(rv), 16'h0082);
    @(posedge sys_clk);
    link_run <= 1'b1;
    src_run <= 1'b1;
    frames(2);
    chk({2'h0, pcm_cfg, osr}, 16'h3020);
    chk(16'(fs_period), 16'h0096);
    rd(8'h0a, rv);
    chk(16'(rv), 16'h0012);
    do_reset(6'h15);
    tally_and_finish();
  end
endmodule : dac_speed_filter_bitstream_ctrl_test

/* verification/dsb_src_model.sv */
`timescale 1ns/1ps
module dsb_src_model (
  input wire logic link_clk,
  input wire logic run,
  input wire logic pm_bad,
  input wire logic [11:0] period,
  input wire logic [5:0] stuck_mask,
  output logic frame_clk_o,
  output logic [5:0] stream_o
);
  logic [11:0] cnt = '0;
  logic [1:0] bit_cnt = '0;
  logic fr = 1'b0;
  logic [5:0] dat = '0;
  logic [5:0] next_dat;
  // nominal levels only, volume is host side
  always_comb begin
    next_dat = {6{bit_cnt[0]}} ^ 6'h15;
    if (pm_bad) begin
      // broken pairs in any alignment, never long enough to look stuck
      next_dat[0] = (bit_cnt == 2'h3);
    end
  end
  // source launches on the falling edge so the sampling edge sees settled data
  always_ff @(negedge link_clk) begin
    if (!run) begin
      cnt <= '0;
      fr <= 1'b0;
    end else begin
      cnt <= (cnt >= period - 12'd1) ? 12'd0 : cnt + 12'd1;
      fr <= (cnt < (period >> 1));
    end
    bit_cnt <= bit_cnt + 2'd1;
    dat <= next_dat | stuck_mask;
  end
  assign frame_clk_o = fr;
  assign stream_o = dat;
endmodule : dsb_src_model
